// file: core/tcct_pkg.sv
package tcct_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [5:0] OFF_STATUS_CTRL = 6'h00;
    localparam logic [5:0] OFF_COUNTER     = 6'h04;
    localparam logic [5:0] OFF_MODULO      = 6'h08;
    localparam logic [5:0] OFF_CH0_SC      = 6'h0C;
    localparam logic [5:0] OFF_CH0_VALUE   = 6'h10;
    localparam logic [5:0] OFF_CH1_SC      = 6'h14;
    localparam logic [5:0] OFF_CH1_VALUE   = 6'h18;
    localparam logic [5:0] OFF_PIN_STATUS  = 6'h1C;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int POS_PS        = 0;
    localparam int POS_RESET     = 4;
    localparam int POS_HALT      = 5;
    localparam int POS_OVF_IE    = 6;
    localparam int POS_OVF_FLAG  = 7;
    localparam int POS_CH_LEVEL  = 0;
    localparam int POS_CH_EDGE   = 2;
    localparam int POS_CH_MODE   = 4;
    localparam int POS_CH_TOV    = 6;
    localparam int POS_CH_IE     = 7;
    localparam int POS_CH_FLAG   = 8;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] RST_MODULO   = 16'hFFFF;
    localparam logic [2:0]  RST_PS       = 3'h0;
    localparam logic        RST_HALT     = 1'b1;
    localparam logic [15:0] RST_COUNTER  = 16'h0000;

    // ****************************************
    // Prescaler select codes
    // ****************************************
    localparam logic [2:0] PS_EXT_CLOCK = 3'h7;

    // ****************************************
    // Channel mode field
    // ****************************************
    localparam logic [1:0] MODE_CAPTURE  = 2'h0;
    localparam logic [1:0] MODE_COMPARE  = 2'h1;
    localparam logic [1:0] MODE_BUFFERED = 2'h2;

    // ****************************************
    // Edge and level codes
    // ****************************************
    typedef enum logic [1:0] {
        EDGE_NONE    = 2'b00,
        EDGE_RISING  = 2'b01,
        EDGE_FALLING = 2'b10,
        EDGE_ANY     = 2'b11
    } tcct_edge_t;

    typedef enum logic [1:0] {
        ACT_NONE   = 2'b00,
        ACT_TOGGLE = 2'b01,
        ACT_CLEAR  = 2'b10,
        ACT_SET    = 2'b11
    } tcct_action_t;

    // ****************************************
    // Channel configuration carrier
    // ****************************************
    typedef struct packed {
        logic         irqEnable;
        logic         toggleOnWrap;
        logic [1:0]   mode;
        tcct_edge_t   trigger;
        tcct_action_t action;
    } tcct_chan_cfg_t;

    // ****************************************
    // Bus response codes
    // ****************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tcct_pkg

// file: core/tcct_timer.sv
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module tcct_timer (
    // Clock, enable, reset
    input  wire logic        mclk,
    input  wire logic        clkEn,
    input  wire logic        rst_n,
    // AXI4-Lite write address
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Shared port pins: timer function or general purpose
    input  wire logic        chan0_pin_in,
    output logic             chan0_pin_out,
    output logic             chan0_pin_oe,
    input  wire logic        chan1_pin_in,
    output logic             chan1_pin_out,
    output logic             chan1_pin_oe,
    input  wire logic        ext_timer_clock_pin,
    // Port-side general-purpose drive, used while the timer releases a pin
    input  wire logic [1:0]  gpioOut,
    input  wire logic [1:0]  gpioOe,
    // Interrupt requests
    output logic             overflowIrq,
    output logic [1:0]       chanIrq
);

    // ****************************************
    // Reset release and pin synchronisers
    // ****************************************
    logic       rstSync1_reg;
    logic       rstSync2_reg;
    logic [2:0] pinSync1_reg;
    logic [2:0] pinSync2_reg;
    logic [2:0] pinPrev_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync1_reg <= 1'b0;
            rstSync2_reg <= 1'b0;
        end else begin
            rstSync1_reg <= 1'b1;
            rstSync2_reg <= rstSync1_reg;
        end
    end

    wire logic rstInt_n = rstSync2_reg;

    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            pinSync1_reg <= 3'h0;
            pinSync2_reg <= 3'h0;
            pinPrev_reg  <= 3'h0;
        end else if (clkEn) begin
            pinSync1_reg <= {ext_timer_clock_pin, chan1_pin_in, chan0_pin_in};
            pinSync2_reg <= pinSync1_reg;
            pinPrev_reg  <= pinSync2_reg;
        end
    end

    wire logic [2:0] pinRise = pinSync2_reg & ~pinPrev_reg;
    wire logic [2:0] pinFall = ~pinSync2_reg & pinPrev_reg;

    // ****************************************
    // Control state
    // ****************************************
    logic [2:0]           psSel_reg;
    logic                 halt_reg;
    logic                 ovfIe_reg;
    logic                 ovfFlag_reg;
    logic [15:0]          modulo_reg;
    logic [15:0]          counter_reg;
    logic [6:0]           prescale_reg;
    tcct_pkg::tcct_chan_cfg_t [1:0] cfg_reg;
    logic [1:0]           chFlag_reg;
    logic [15:0]          chValue_reg [2];
    logic                 activeCh_reg;
    logic                 pendingCh_reg;
    logic [1:0]           pinLevel_reg;

    // ****************************************
    // Bus slave handshake
    // ****************************************
    logic        awHeld_reg;
    logic [5:0]  awAddr_reg;
    logic        wHeld_reg;
    logic [31:0] wData_reg;
    logic [3:0]  wStrb_reg;

    wire logic awTake  = s_axi_awvalid && s_axi_awready;
    wire logic wTake   = s_axi_wvalid && s_axi_wready;
    wire logic wrGo    = clkEn && awHeld_reg && wHeld_reg && !s_axi_bvalid;
    wire logic rdTake  = clkEn && s_axi_arvalid && s_axi_arready;
    wire logic [5:0] wa = awAddr_reg;
    wire logic lowLane = wStrb_reg[0];
    wire logic hiLane  = wStrb_reg[1];

    wire logic wrSc    = wrGo && wa == tcct_pkg::OFF_STATUS_CTRL;
    wire logic wrMod   = wrGo && wa == tcct_pkg::OFF_MODULO;
    wire logic wrCh0Sc = wrGo && wa == tcct_pkg::OFF_CH0_SC;
    wire logic wrCh1Sc = wrGo && wa == tcct_pkg::OFF_CH1_SC;
    wire logic wrCh0V  = wrGo && wa == tcct_pkg::OFF_CH0_VALUE;
    wire logic wrCh1V  = wrGo && wa == tcct_pkg::OFF_CH1_VALUE;
    wire logic wrHit   = wrSc || wrMod || wrCh0Sc || wrCh1Sc || wrCh0V || wrCh1V
                         || (wrGo && (wa == tcct_pkg::OFF_COUNTER
                                      || wa == tcct_pkg::OFF_PIN_STATUS));
    wire logic [1:0] wrChV  = {wrCh1V, wrCh0V};
    wire logic [1:0] wrChSc = {wrCh1Sc, wrCh0Sc};

    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            awHeld_reg    <= 1'b0;
            wHeld_reg     <= 1'b0;
            awAddr_reg    <= 6'h00;
            wData_reg     <= 32'h0000_0000;
            wStrb_reg     <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= tcct_pkg::RESP_OKAY;
        end else if (clkEn) begin
            if (awTake) begin
                awHeld_reg    <= 1'b1;
                awAddr_reg    <= {s_axi_awaddr[5:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (wTake) begin
                wHeld_reg    <= 1'b1;
                wData_reg    <= s_axi_wdata;
                wStrb_reg    <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wrGo) begin
                awHeld_reg   <= 1'b0;
                wHeld_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? tcct_pkg::RESP_OKAY : tcct_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ****************************************
    // Prescaler and count tick
    // ****************************************
    wire logic [7:0] divTaps  = {1'b0, prescale_reg};
    wire logic [7:0] divNext  = divTaps + 8'h01;
    wire logic [6:0] divRise  = divNext[6:0] & ~prescale_reg;
    wire logic [7:0] tickSel  = {pinRise[2], 1'b0, divRise[5:0]};
    wire logic       rawTick  = psSel_reg == tcct_pkg::PS_EXT_CLOCK ? pinRise[2]
                                : (psSel_reg == 3'h0 ? 1'b1 : tickSel[psSel_reg - 3'h1]);
    wire logic       tick     = clkEn && rawTick && !halt_reg;
    wire logic       atModulo = counter_reg == modulo_reg;
    wire logic       wrapTick = tick && atModulo;
    wire logic       ctrReset = wrSc && lowLane && wData_reg[tcct_pkg::POS_RESET];

    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            prescale_reg <= 7'h00;
            counter_reg  <= tcct_pkg::RST_COUNTER;
        end else if (clkEn) begin
            if (ctrReset) begin
                prescale_reg <= 7'h00;
                counter_reg  <= tcct_pkg::RST_COUNTER;
            end else begin
                prescale_reg <= divNext[6:0];
                if (wrapTick) begin
                    counter_reg <= 16'h0000;
                end else if (tick) begin
                    counter_reg <= counter_reg + 16'h0001;
                end
            end
        end
    end

    // ****************************************
    // Global control and overflow flag
    // ****************************************
    wire logic ovfEvent = tick && atModulo;
    wire logic ovfClear = wrSc && lowLane && !wData_reg[tcct_pkg::POS_OVF_FLAG];

    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            psSel_reg   <= tcct_pkg::RST_PS;
            halt_reg    <= tcct_pkg::RST_HALT;
            ovfIe_reg   <= 1'b0;
            ovfFlag_reg <= 1'b0;
            modulo_reg  <= tcct_pkg::RST_MODULO;
        end else if (clkEn) begin
            if (wrSc && lowLane) begin
                psSel_reg <= wData_reg[tcct_pkg::POS_PS +: 3];
                halt_reg  <= wData_reg[tcct_pkg::POS_HALT];
                ovfIe_reg <= wData_reg[tcct_pkg::POS_OVF_IE];
            end
            if (ovfEvent) begin
                ovfFlag_reg <= 1'b1;
            end else if (ovfClear) begin
                ovfFlag_reg <= 1'b0;
            end
            if (wrMod && lowLane) begin
                modulo_reg[7:0] <= wData_reg[7:0];
            end
            if (wrMod && hiLane) begin
                modulo_reg[15:8] <= wData_reg[15:8];
            end
        end
    end

    // ****************************************
    // Linked-pair selection
    // ****************************************
    wire logic linked = cfg_reg[0].mode[1];
    wire logic [1:0] effMode0 = linked ? tcct_pkg::MODE_BUFFERED : cfg_reg[0].mode;
    wire logic [1:0] effMode1 = linked ? tcct_pkg::MODE_CAPTURE : cfg_reg[1].mode;

    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            activeCh_reg  <= 1'b0;
            pendingCh_reg <= 1'b0;
        end else if (clkEn) begin
            if (!linked) begin
                activeCh_reg  <= 1'b0;
                pendingCh_reg <= 1'b0;
            end else begin
                if (wrCh1V) begin
                    pendingCh_reg <= 1'b1;
                end else if (wrCh0V) begin
                    pendingCh_reg <= 1'b0;
                end
                if (ovfEvent) begin
                    activeCh_reg <= wrCh1V ? 1'b1 : (wrCh0V ? 1'b0 : pendingCh_reg);
                end
            end
        end
    end

    wire logic [15:0] bufValue = chValue_reg[activeCh_reg];

    // ****************************************
    // Per-channel capture and compare
    // ****************************************
    logic [1:0] chEvent;
    logic [1:0] pinNext;

    for (genvar c = 0; c < 2; c++) begin : g_chan
        wire logic [1:0]      mode    = c == 0 ? effMode0 : effMode1;
        wire logic            isCap   = mode == tcct_pkg::MODE_CAPTURE;
        wire tcct_pkg::tcct_edge_t edgeSel = cfg_reg[c].trigger;
        wire logic            capEdge = !(c == 1 && linked)
                                        && ((edgeSel[0] && pinRise[c])
                                            || (edgeSel[1] && pinFall[c]));
        wire logic [15:0]     cmpVal  = (c == 0 && linked) ? bufValue : chValue_reg[c];
        wire logic            match   = !isCap && tick && counter_reg == cmpVal;
        wire tcct_pkg::tcct_action_t act = cfg_reg[c].action;
        logic                 lvl;

        always_comb begin
            lvl = pinLevel_reg[c];
            if (match) begin
                case (act)
                    tcct_pkg::ACT_TOGGLE: lvl = ~lvl;
                    tcct_pkg::ACT_CLEAR:  lvl = 1'b0;
                    tcct_pkg::ACT_SET:    lvl = 1'b1;
                    default:              lvl = lvl;
                endcase
            end
            if (!isCap && ovfEvent && cfg_reg[c].toggleOnWrap) begin
                lvl = ~lvl;
            end
        end

        assign pinNext[c] = lvl;
        assign chEvent[c] = (isCap && capEdge) || match;

        always_ff @(posedge mclk or negedge rstInt_n) begin
            if (!rstInt_n) begin
                cfg_reg[c]     <= '0;
                chFlag_reg[c]  <= 1'b0;
                chValue_reg[c] <= 16'h0000;
            end else if (clkEn) begin
                if (wrChSc[c] && lowLane) begin
                    cfg_reg[c] <= wData_reg[7:0];
                end
                if (chEvent[c]) begin
                    chFlag_reg[c] <= 1'b1;
                end else if (wrChSc[c] && hiLane && !wData_reg[tcct_pkg::POS_CH_FLAG]) begin
                    chFlag_reg[c] <= 1'b0;
                end
                if (isCap && capEdge) begin
                    chValue_reg[c] <= counter_reg;
                end else if (wrChV[c]) begin
                    if (lowLane) chValue_reg[c][7:0]  <= wData_reg[7:0];
                    if (hiLane)  chValue_reg[c][15:8] <= wData_reg[15:8];
                end
            end
        end
    end

    // ****************************************
    // Pin drive and interrupt outputs
    // ****************************************
    wire logic ch0Drive = effMode0 != tcct_pkg::MODE_CAPTURE;
    wire logic ch1Drive = effMode1 != tcct_pkg::MODE_CAPTURE;

    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            pinLevel_reg  <= 2'h0;
            chan0_pin_out <= 1'b0;
            chan0_pin_oe  <= 1'b0;
            chan1_pin_out <= 1'b0;
            chan1_pin_oe  <= 1'b0;
            overflowIrq   <= 1'b0;
            chanIrq       <= 2'h0;
        end else if (clkEn) begin
            pinLevel_reg  <= pinNext;
            chan0_pin_out <= ch0Drive ? pinNext[0] : gpioOut[0];
            chan0_pin_oe  <= ch0Drive ? 1'b1 : gpioOe[0];
            chan1_pin_out <= ch1Drive ? pinNext[1] : gpioOut[1];
            chan1_pin_oe  <= ch1Drive ? 1'b1 : gpioOe[1];
            overflowIrq   <= (ovfFlag_reg || ovfEvent) && ovfIe_reg;
            chanIrq[0]    <= (chFlag_reg[0] || chEvent[0]) && cfg_reg[0].irqEnable;
            chanIrq[1]    <= (chFlag_reg[1] || chEvent[1]) && cfg_reg[1].irqEnable
                             && !linked;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    wire logic [5:0] ra = {s_axi_araddr[5:2], 2'b00};
    wire logic rdHit = ra <= tcct_pkg::OFF_PIN_STATUS;
    wire logic [31:0] rdMux =
        ra == tcct_pkg::OFF_STATUS_CTRL ? {24'h0, ovfFlag_reg, ovfIe_reg, halt_reg,
                                           1'b0, 1'b0, psSel_reg} :
        ra == tcct_pkg::OFF_COUNTER     ? {16'h0, counter_reg} :
        ra == tcct_pkg::OFF_MODULO      ? {16'h0, modulo_reg} :
        ra == tcct_pkg::OFF_CH0_SC      ? {23'h0, chFlag_reg[0], cfg_reg[0]} :
        ra == tcct_pkg::OFF_CH0_VALUE   ? {16'h0, chValue_reg[0]} :
        ra == tcct_pkg::OFF_CH1_SC      ? {23'h0, chFlag_reg[1], cfg_reg[1]} :
        ra == tcct_pkg::OFF_CH1_VALUE   ? {16'h0, chValue_reg[1]} :
        {27'h0, activeCh_reg, linked, pinSync2_reg[1:0], 1'b0};

    always_ff @(posedge mclk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= tcct_pkg::RESP_OKAY;
        end else if (clkEn) begin
            if (rdTake) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rdHit ? rdMux : 32'h0000_0000;
                s_axi_rresp   <= rdHit ? tcct_pkg::RESP_OKAY : tcct_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule : tcct_timer

// file: testbench/tcct_pin_model.sv
`timescale 1ns/100ps
module tcct_pin_model (
    // Design drive
    input  wire logic [1:0] pinOut,
    input  wire logic [1:0] pinOe,
    // Event source drive
    input  wire logic [1:0] srcLevel,
    input  wire logic [1:0] srcEn,
    // Resolved pin levels
    output logic      [1:0] pinLevel
);
    // ****************
    // Shared pins, pulled up when free
    // ****************
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pinLevel[i] = pinOe[i] ? pinOut[i] : (srcEn[i] ? srcLevel[i] : 1'h1);
        end
    end
endmodule : tcct_pin_model

// file: testbench/tcct_timer_asserts.sv
`timescale 1ns/100ps
module tcct_timer_asserts (
    // Clock, reset and bus handshakes
    input wire logic        mclk, clkEn, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
    input wire logic        s_axi_arready, s_axi_rvalid, s_axi_rready, overflowIrq,
    // Responses and requests
    input wire logic [1:0]  s_axi_bresp, s_axi_rresp, chanIrq,
    input wire logic [31:0] s_axi_rdata
);
    // ****************
    // Bus and irq checks
    // ****************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && clkEn |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    a_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read busy");
    a_refuse_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("refused read data not zero");
    a_irq_quiet: assert property ($rose(rst_n) |-> !overflowIrq && chanIrq == 2'h0)
        else $error("irq after reset");
    c_write_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    c_read_done: cover property (s_axi_rvalid && s_axi_rready);
    c_both_chan: cover property (chanIrq == 2'h3);
    c_overflow: cover property (overflowIrq);
endmodule : tcct_timer_asserts
bind tcct_timer tcct_timer_asserts u_asserts (.mclk, .clkEn, .rst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .overflowIrq, .s_axi_bresp, .s_axi_rresp,
    .chanIrq, .s_axi_rdata);

// file: testbench/tcct_timer_test.sv
`timescale 1ns/100ps
module tcct_timer_test;
    // ****************
    // Bench
    // ****************
    logic        mclk = 1'h0, rst_n = 1'h0, clkEn = 1'h1, ext_timer_clock_pin = 1'h0, p0 = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, overflowIrq;
    logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic [3:0]  s_axi_wstrb = 4'hF, watch;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q, c;
    logic [1:0]  s_axi_bresp, s_axi_rresp, chanIrq, pinOut, pinOe, pinLevel, r;
    logic [1:0]  gpioOut = 2'h0, gpioOe = 2'h0, srcLevel = 2'h0, srcEn = 2'h3;
    logic [39:0] rows [5] = '{{6'h00, 32'h20, 2'h0}, {6'h04, 32'h0, 2'h0},
        {6'h08, 32'hFFFF, 2'h0}, {6'h20, 32'h0, 2'h2}, {6'h3C, 32'h0, 2'h2}};
    int          numErrors = 0, numChecks = 0;
    assign watch = {pinOut[0] ^ p0, overflowIrq, chanIrq};
    tcct_timer uut (.mclk, .clkEn, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chan0_pin_in(pinLevel[0]),
        .chan0_pin_out(pinOut[0]), .chan0_pin_oe(pinOe[0]), .chan1_pin_in(pinLevel[1]),
        .chan1_pin_out(pinOut[1]), .chan1_pin_oe(pinOe[1]), .ext_timer_clock_pin, .gpioOut,
        .gpioOe, .overflowIrq, .chanIrq);
    tcct_pin_model pins (.pinOut, .pinOe, .srcLevel, .srcEn, .pinLevel);
    initial begin
        forever #20 mclk = ~mclk;
    end
    task automatic results;
        $display("checks %0d errors %0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        numChecks++;
        if (g !== e) begin
            numErrors++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        logic aw, w, ar;
        n = 0;
        aw = wr;
        w = wr;
        ar = !wr;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_bready <= wr;
        s_axi_rready <= !wr;
        do begin
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
            s_axi_arvalid <= ar;
            @(posedge mclk);
            n++;
            aw = aw && s_axi_awready !== 1'h1;
            w = w && s_axi_wready !== 1'h1;
            ar = ar && s_axi_arready !== 1'h1;
        end while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'h1 && n < 50);
        q = s_axi_rdata;
        r = wr ? s_axi_bresp : s_axi_rresp;
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        s_axi_arvalid <= 1'h0;
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        chk("bus wait", 32'h0, 32'(n >= 50));
        if (n >= 50) results;
        @(posedge mclk);
    endtask : bus
    task automatic waitSig(input int i);
        int n;
        n = 0;
        while (watch[i] !== 1'h1 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        chk("event wait", 32'h0, 32'(n >= 300));
        if (n >= 300) results;
    endtask : waitSig
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'h1;
        repeat (3) @(posedge mclk);
        foreach (rows[i]) begin
            bus(1'h0, rows[i][39:34], 32'h0);
            chk("read data", rows[i][33:2], q);
            chk("read resp", 32'(rows[i][1:0]), 32'(r));
        end
        bus(1'h1, 6'h24, 32'h0);
        chk("write resp", 32'h2, 32'(r));
        bus(1'h1, 6'h08, 32'h000F);
        bus(1'h1, 6'h10, 32'h0020);
        bus(1'h1, 6'h0C, 32'h91);
        p0 = pinOut[0];
        bus(1'h1, 6'h00, 32'h41);
        waitSig(2);
        repeat (40) @(posedge mclk);
        chk("idle pin", 32'(p0), 32'(pinOut[0]));
        chk("idle irq", 32'h0, 32'(chanIrq[0]));
        bus(1'h0, 6'h04, 32'h0);
        chk("count range", 32'h1, 32'(q[15:0] <= 16'h000F));
        bus(1'h1, 6'h10, 32'h0005);
        waitSig(3);
        waitSig(0);
        bus(1'h1, 6'h10, 32'h0003);
        bus(1'h0, 6'h10, 32'h0);
        chk("lowered value", 32'h3, q);
        bus(1'h1, 6'h00, 32'h20);
        bus(1'h0, 6'h04, 32'h0);
        c = q;
        bus(1'h0, 6'h04, 32'h0);
        chk("held count", c, q);
        bus(1'h1, 6'h14, 32'h84);
        srcLevel <= 2'h2;
        waitSig(1);
        bus(1'h0, 6'h18, 32'h0);
        chk("capture", c, q);
        bus(1'h1, 6'h14, 32'h88);
        chk("flag clear", 32'h0, 32'(chanIrq[1]));
        srcLevel <= 2'h0;
        waitSig(1);
        bus(1'h1, 6'h00, 32'h30);
        bus(1'h0, 6'h04, 32'h0);
        chk("counter reset", 32'h0, q);
        bus(1'h1, 6'h00, 32'h07);
        clkEn <= 1'h0;
        ext_timer_clock_pin <= 1'h1;
        repeat (4) @(posedge mclk);
        ext_timer_clock_pin <= 1'h0;
        repeat (4) @(posedge mclk);
        clkEn <= 1'h1;
        repeat (3) begin
            ext_timer_clock_pin <= 1'h1;
            repeat (3) @(posedge mclk);
            ext_timer_clock_pin <= 1'h0;
            repeat (3) @(posedge mclk);
        end
        bus(1'h0, 6'h04, 32'h0);
        chk("ext count", 32'h3, q);
        bus(1'h1, 6'h14, 32'h190);
        bus(1'h1, 6'h0C, 32'h70);
        gpioOe <= 2'h2;
        gpioOut <= 2'h2;
        repeat (4) @(posedge mclk);
        chk("free pin", 32'h3, 32'({pinOe[1], pinOut[1]}));
        chk("ch1 irq", 32'h0, 32'(chanIrq[1]));
        bus(1'h1, 6'h18, 32'h0009);
        p0 = pinOut[0];
        bus(1'h1, 6'h00, 32'h40);
        waitSig(2);
        bus(1'h0, 6'h1C, 32'h0);
        chk("active pair", 32'h3, 32'(q[4:3]));
        bus(1'h1, 6'h10, 32'h000C);
        repeat (20) @(posedge mclk);
        bus(1'h0, 6'h1C, 32'h0);
        chk("pair back", 32'h1, 32'(q[4:3]));
        waitSig(3);
        results;
    end
endmodule : tcct_timer_test
